// ==== hw/arc_pkg.sv ====
// Shared register map, field layouts, reset values and state types for the rate/cal controller.
package arc_pkg;

    // Register word addresses.
    localparam logic [7:0] A_SETUP0    = 8'h00;
    localparam logic [7:0] A_BGCAL     = 8'h08;
    localparam logic [7:0] A_SCAN      = 8'h09;
    localparam logic [7:0] A_SYSCAL    = 8'h0A;
    localparam logic [7:0] A_CLOCK     = 8'h0B;
    localparam logic [7:0] A_GPIO_DIR  = 8'h0C;
    localparam logic [7:0] A_GPIO_OUT  = 8'h0D;
    localparam logic [7:0] A_GPIO_IN   = 8'h0E;
    localparam logic [7:0] A_RESULT    = 8'h0F;
    localparam logic [7:0] A_OFFSET0   = 8'h10;
    localparam logic [7:0] A_GAIN0     = 8'h14;
    localparam logic [7:0] A_BG_OFFSET = 8'h18;

    // Field positions.
    localparam int F_BG_FGA    = 2;
    localparam int F_SCAN_LAST = 4;
    localparam int F_SCAN_RUN  = 8;
    localparam int F_SC_CHAN   = 4;
    localparam int F_CLK_DET   = 0;
    localparam int F_CLK_EXT   = 1;
    localparam int F_CLK_XTAL  = 2;
    localparam int F_CLK_OSC   = 3;
    localparam int F_RES_CHAN  = 24;

    // Reset values and limits.
    localparam logic [2:0]  RATE_RST  = 3'h7;
    localparam logic [23:0] GAIN_RST  = 24'h80_0000;
    localparam logic [23:0] POS_FULL  = 24'h7F_FFFF;
    localparam logic [23:0] NEG_FULL  = 24'h80_0000;
    localparam logic [23:0] U_FULL    = 24'hFF_FFFF;
    localparam logic [5:0]  DIV_STEPS = 6'h30;

    // System calibration commands.
    localparam logic [1:0] SC_OFF    = 2'h0;
    localparam logic [1:0] SC_OFFSET = 2'h1;
    localparam logic [1:0] SC_GAIN   = 2'h3;

    typedef enum logic [1:0] {
        BG_OFF   = 2'h0,
        BG_OC_GE = 2'h1,
        BG_OG_C  = 2'h2,
        BG_OG_E  = 2'h3
    } arc_bg_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_DIV  = 4'b0100,
        ST_DONE = 4'b1000
    } arc_fsm_t;

    typedef struct packed {
        logic       unity_gain_buffer;
        logic       fga_bypass;
        logic [1:0] programmable_gain_amplifier;
        logic [2:0] output_rate_select;
    } arc_setup_t;

    typedef struct packed {
        arc_setup_t [6:0]  setup;
        arc_bg_mode_t      bg_mode;
        logic              fixed_amp_background_cal;
        logic [2:0]        first;
        logic [2:0]        last;
        logic              run;
        logic [1:0]        sc_mode;
        logic [1:0]        sc_chan;
        logic              sc_busy;
        logic              det_en;
        logic              ext_sel;
        logic [6:0]        gpio_dir;
        logic [6:0]        gpio_out;
        logic [6:0]        g1;
        logic [6:0]        g2;
        logic [6:0]        g3;
        logic [6:0]        gpio_in;
        logic              x1;
        logic              x2;
        logic              x3;
        logic              xtal;
        arc_fsm_t          fsm;
        logic [2:0]        chan;
        logic              cal_slot;
        logic [21:0]       cnt;
        logic [23:0]       raw;
        logic [3:0][23:0]  offs;
        logic [3:0][23:0]  gains;
        logic [23:0]       bg_off;
        logic [47:0]       dvd;
        logic [47:0]       quo;
        logic [24:0]       rem;
        logic [23:0]       dvs;
        logic [5:0]        step;
        logic              neg;
        logic [23:0]       result;
        logic [2:0]        res_ch;
        logic              res_valid;
        logic              conv_start;
        logic [31:0]       rdata;
    } arc_state_t;

endpackage : arc_pkg

// ==== hw/arc_ctrl.sv ====
// Rate, clock, GPIO and calibration control around a 24-bit sigma-delta converter.
//
// Operation
// RL1 - Buffer forced in when total gain is 16 or more, else per-channel bit.
// RL2 - Crystal found in detect mode shuts off internal oscillator, runs external.
// RL3 - Per-channel three-bit rate select picks eight rates; fastest is reset default.
// RL4 - Base rates are clock over 266240 and 16640, each divided by 1,2,4,8.
// RL5 - Rate setting is stored separately for every channel.
// RL6 - Scanned channels share time, so each gets its rate divided by n.
// RL7 - Sinc filter sets rate; mains rejection only at rate 13.42 or lower.
// RL8 - Other clocks keep filter shape; frequencies scale with the clock.
// RL9 - Seven general pins, each driven high/low or read high/low.
// RL10 - Correction recomputes coefficients; estimation applies last known or factory values.
// RL11 - Background calibration covers four channels, each keeping gain and rate.
// RL12 - Background mode field: off, offset-correct, full correct, full estimate.
// RL13 - Full correction with amplifier bit clear costs one fast slot per round.
// RL14 - Offset coefficient is signed 24-bit; gain coefficient is unsigned 1.23.
// RL15 - Result is raw minus offset coefficient, then divided by gain coefficient.
// RL16 - Four coefficient sets; channels 4, 5, 6 reuse sets 0, 1, 2.
// RL17 - Host runs offset determination before gain determination on a channel.
// RL18 - Offset determination stores a coefficient making the zero condition read zero.
// RL19 - Host loads desired code first; device computes gain reaching that code.
// RL20 - Total gain is fixed amplifier 16 or 1 times programmable 1,2,4,8.
// RL21 - Command 1 starts a fresh conversion, stores offset, then clears itself.
// RL22 - Command 3 starts a fresh conversion, overwrites gain, then clears itself.
// RL23 - Calibrated result saturates to 24-bit range instead of wrapping.
//
// The implementer's own choices: the address map and the strobed register port.
module arc_ctrl #(
    parameter int          DIV_SLOW          = 266240,
    parameter int          DIV_FAST          = 16640,
    parameter logic [23:0] FACTORY_BG_OFFSET = 24'h00_0000
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic        raw_valid,
    input  wire logic [23:0] raw_data,
    output logic             conv_start,
    output logic      [2:0]  conv_channel,
    output logic             conv_is_cal,
    output logic      [2:0]  output_rate,
    output logic             unity_gain_buffer,
    output logic      [7:0]  total_gain,
    output logic             mains_rejection,
    output logic      [23:0] result,
    output logic      [2:0]  result_channel,
    output logic             result_valid,
    input  wire logic [6:0]  general_purpose_pins_in,
    output logic      [6:0]  general_purpose_pins_out,
    output logic      [6:0]  general_purpose_pins_oe_n,
    input  wire logic        crystal_present,
    output logic             internal_osc_enable,
    output logic             clock_from_external
);

    arc_pkg::arc_state_t q;
    arc_pkg::arc_state_t n;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [21:0] slot_len(input logic [2:0] sel);
        logic [21:0] base;
        base = sel[2] ? 22'(DIV_FAST) : 22'(DIV_SLOW); // RL4
        return base << (2'h3 - sel[1:0]); // RL4
    endfunction : slot_len

    function automatic logic [7:0] gain_of(input arc_pkg::arc_setup_t s);
        return (s.fga_bypass ? 8'h01 : 8'h10) << s.programmable_gain_amplifier; // RL20
    endfunction : gain_of

    // Channels 4..6 land on sets 0..2 through their low bits.
    function automatic logic [1:0] coef_set(input logic [2:0] ch);
        return ch[1:0]; // RL16
    endfunction : coef_set

    function automatic logic [23:0] sat24(input logic [24:0] v);
        if (v[24] != v[23]) begin
            return v[24] ? arc_pkg::NEG_FULL : arc_pkg::POS_FULL; // RL23
        end
        return v[23:0];
    endfunction : sat24

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    logic        pick;
    logic        go;
    logic        go_cal;
    logic [2:0]  go_ch;
    logic [2:0]  nxt;
    logic [1:0]  set;
    logic [23:0] rawv;
    logic [23:0] corr;
    logic [24:0] diff;
    logic [24:0] mag;
    logic [24:0] rem_t;
    logic        qb;

    always_comb begin
        n            = q;
        pick         = 1'b0;
        go           = 1'b0;
        go_cal       = 1'b0;
        go_ch        = q.chan;
        set          = coef_set(q.chan);
        nxt          = (q.chan == q.last) ? q.first : 3'(q.chan + 3'h1); // RL6
        rawv         = raw_valid ? raw_data : q.raw;
        corr         = (q.bg_mode == arc_pkg::BG_OFF) ? rawv
                     : sat24({rawv[23], rawv} - {q.bg_off[23], q.bg_off}); // RL10
        diff         = {corr[23], corr} - {q.offs[set][23], q.offs[set]}; // RL15
        mag          = diff[24] ? 25'(-diff) : diff;
        rem_t        = {q.rem[23:0], q.dvd[47]};
        qb           = rem_t >= {1'b0, q.dvs};
        n.conv_start = 1'b0;
        n.res_valid  = 1'b0;
        n.rdata      = 32'h0000_0000;

        // Pin synchronisers; a bit moves only when the last two stages agree.
        n.g1      = general_purpose_pins_in;
        n.g2      = q.g1;
        n.g3      = q.g2;
        n.gpio_in = (q.g2 & q.g3) | (q.gpio_in & (q.g2 ^ q.g3)); // RL9
        n.x1      = crystal_present;
        n.x2      = q.x1;
        n.x3      = q.x2;
        if (q.x2 == q.x3) begin
            n.xtal = q.x3;
        end

        case (q.fsm)
            arc_pkg::ST_IDLE: begin
                pick = 1'b1;
            end
            arc_pkg::ST_CONV: begin
                if (raw_valid) begin
                    n.raw = raw_data;
                end
                n.cnt = q.cnt - 22'h1;
                if (q.sc_mode != arc_pkg::SC_OFF && !q.sc_busy) begin
                    pick = 1'b1; // RL21
                end else if (q.cnt == 22'h1) begin
                    if (q.cal_slot) begin
                        // Correction modes refresh the term; estimation keeps the last one.
                        if (q.bg_mode == arc_pkg::BG_OC_GE || q.bg_mode == arc_pkg::BG_OG_C) begin
                            n.bg_off = rawv; // RL10
                        end
                        pick = 1'b1;
                    end else if (q.sc_busy && q.sc_mode == arc_pkg::SC_OFFSET) begin
                        n.offs[set] = corr; // RL18
                        n.sc_mode   = arc_pkg::SC_OFF; // RL21
                        n.sc_busy   = 1'b0;
                        pick        = 1'b1;
                    end else begin
                        // The gain register holds the desired code during determination.
                        if (q.sc_busy && q.sc_mode == arc_pkg::SC_GAIN) begin
                            n.neg = 1'b0;
                            n.dvd = diff[24] ? 48'h0 : {diff, 23'h0}; // RL19
                        end else begin
                            n.neg = diff[24];
                            n.dvd = {mag, 23'h0}; // RL15
                        end
                        n.dvs  = q.gains[set]; // RL14
                        n.rem  = 25'h0;
                        n.quo  = 48'h0;
                        n.step = arc_pkg::DIV_STEPS;
                        n.fsm  = arc_pkg::ST_DIV;
                    end
                end
            end
            arc_pkg::ST_DIV: begin
                // Restoring division, one quotient bit a cycle; a zero gain saturates.
                n.rem  = qb ? 25'(rem_t - {1'b0, q.dvs}) : rem_t; // RL15
                n.dvd  = {q.dvd[46:0], 1'b0};
                n.quo  = {q.quo[46:0], qb};
                n.step = q.step - 6'h1;
                if (q.step == 6'h1) begin
                    n.fsm = arc_pkg::ST_DONE;
                end
            end
            arc_pkg::ST_DONE: begin
                if (q.sc_busy && q.sc_mode == arc_pkg::SC_GAIN) begin
                    n.gains[set] = (|q.quo[47:24]) ? arc_pkg::U_FULL : q.quo[23:0]; // RL22
                    n.sc_mode    = arc_pkg::SC_OFF; // RL22
                end else begin
                    if (q.neg) begin
                        n.result = (q.quo > 48'h80_0000) ? arc_pkg::NEG_FULL
                                 : 24'(~q.quo[23:0] + 24'h1); // RL23
                    end else begin
                        n.result = (q.quo > 48'h7F_FFFF) ? arc_pkg::POS_FULL
                                 : q.quo[23:0]; // RL23
                    end
                    n.res_ch    = q.chan;
                    n.res_valid = 1'b1;
                end
                n.sc_busy = 1'b0;
                pick      = 1'b1;
            end
            default: begin
                n.fsm = arc_pkg::ST_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////////
        // Register port.

        if (rd_en) begin
            case (addr)
                arc_pkg::A_BGCAL:     n.rdata = {29'h0, q.fixed_amp_background_cal, q.bg_mode};
                arc_pkg::A_SCAN:      n.rdata = {23'h0, q.run, 1'b0, q.last, 1'b0, q.first};
                arc_pkg::A_SYSCAL:    n.rdata = {26'h0, q.sc_chan, 2'h0, q.sc_mode};
                arc_pkg::A_CLOCK:     n.rdata = {28'h0, internal_osc_enable, q.xtal,
                                                 q.ext_sel, q.det_en};
                arc_pkg::A_GPIO_DIR:  n.rdata = {25'h0, q.gpio_dir};
                arc_pkg::A_GPIO_OUT:  n.rdata = {25'h0, q.gpio_out};
                arc_pkg::A_GPIO_IN:   n.rdata = {25'h0, q.gpio_in}; // RL9
                arc_pkg::A_RESULT:    n.rdata = {5'h0, q.res_ch, q.result};
                arc_pkg::A_BG_OFFSET: n.rdata = {8'h0, q.bg_off};
                default: begin
                    if (addr[7:3] == 5'h00 && addr[2:0] != 3'h7) begin
                        n.rdata = {25'h0, q.setup[addr[2:0]]};
                    end else if (addr[7:2] == arc_pkg::A_OFFSET0[7:2]) begin
                        n.rdata = {8'h0, q.offs[addr[1:0]]};
                    end else if (addr[7:2] == arc_pkg::A_GAIN0[7:2]) begin
                        n.rdata = {8'h0, q.gains[addr[1:0]]};
                    end
                end
            endcase
        end

        if (wr_en) begin
            case (addr)
                arc_pkg::A_BGCAL: begin
                    n.bg_mode   = arc_pkg::arc_bg_mode_t'(wdata[1:0]); // RL12
                    n.fixed_amp_background_cal = wdata[arc_pkg::F_BG_FGA];
                end
                arc_pkg::A_SCAN: begin
                    n.first = wdata[2:0];
                    n.last  = wdata[arc_pkg::F_SCAN_LAST +: 3];
                    n.run   = wdata[arc_pkg::F_SCAN_RUN];
                end
                arc_pkg::A_SYSCAL: begin
                    n.sc_mode = wdata[1:0];
                    n.sc_chan = wdata[arc_pkg::F_SC_CHAN +: 2];
                    n.sc_busy = 1'b0;
                end
                arc_pkg::A_CLOCK: begin
                    n.det_en  = wdata[arc_pkg::F_CLK_DET];
                    n.ext_sel = wdata[arc_pkg::F_CLK_EXT];
                end
                arc_pkg::A_GPIO_DIR: n.gpio_dir = wdata[6:0];
                arc_pkg::A_GPIO_OUT: n.gpio_out = wdata[6:0];
                default: begin
                    if (addr[7:3] == 5'h00 && addr[2:0] != 3'h7) begin
                        n.setup[addr[2:0]] = arc_pkg::arc_setup_t'(wdata[6:0]); // RL5
                    end else if (addr[7:2] == arc_pkg::A_OFFSET0[7:2]) begin
                        n.offs[addr[1:0]] = wdata[23:0]; // RL14
                    end else if (addr[7:2] == arc_pkg::A_GAIN0[7:2]) begin
                        n.gains[addr[1:0]] = wdata[23:0]; // RL19
                    end
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////
        // Slot scheduling: calibration command first, then the scan round.

        if (pick) begin
            if (n.sc_mode != arc_pkg::SC_OFF) begin
                go        = 1'b1; // RL21
                go_ch     = {1'b0, n.sc_chan}; // RL11
                n.sc_busy = 1'b1;
            end else if (n.run) begin
                go = 1'b1;
                if (q.fsm != arc_pkg::ST_IDLE && q.chan == q.last && !q.cal_slot
                    && n.bg_mode == arc_pkg::BG_OG_C && !n.fixed_amp_background_cal) begin
                    go_cal = 1'b1; // RL13
                end else begin
                    go_ch = (q.fsm == arc_pkg::ST_IDLE) ? n.first : nxt; // RL6
                end
            end else begin
                n.fsm = arc_pkg::ST_IDLE;
            end
        end

        if (go) begin
            n.fsm        = arc_pkg::ST_CONV;
            n.chan       = go_ch;
            n.cal_slot   = go_cal;
            // Counts are in conversion clocks, so every rate follows the clock.
            n.cnt        = go_cal ? 22'(DIV_FAST)
                         : slot_len(n.setup[go_ch].output_rate_select); // RL8
            n.conv_start = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q        <= '0;
            q.fsm    <= arc_pkg::ST_IDLE;
            q.setup  <= {7{arc_pkg::arc_setup_t'({4'h0, arc_pkg::RATE_RST})}}; // RL3
            q.gains  <= {4{arc_pkg::GAIN_RST}};
            q.bg_off <= FACTORY_BG_OFFSET; // RL10
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign rdata                     = q.rdata;
    assign conv_start                = q.conv_start;
    assign conv_channel              = q.chan;
    assign conv_is_cal               = q.cal_slot;
    assign output_rate               = q.setup[q.chan].output_rate_select; // RL3
    assign total_gain                = gain_of(q.setup[q.chan]); // RL20
    assign unity_gain_buffer         = !q.setup[q.chan].fga_bypass
                                     || q.setup[q.chan].unity_gain_buffer; // RL1
    assign mains_rejection           = !q.setup[q.chan].output_rate_select[2]; // RL7
    assign result                    = q.result;
    assign result_channel            = q.res_ch;
    assign result_valid              = q.res_valid;
    assign general_purpose_pins_out  = q.gpio_out; // RL9
    assign general_purpose_pins_oe_n = ~q.gpio_dir; // RL9
    assign internal_osc_enable       = !(q.ext_sel || (q.det_en && q.xtal)); // RL2
    assign clock_from_external       = !internal_osc_enable; // RL2

endmodule : arc_ctrl

// ==== verif/arc_ctrl_properties.sv ====
// Concurrent checks on the port behaviour of the rate and calibration controller.
module arc_ctrl_properties (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       conv_start,
    input wire logic [2:0] conv_channel,
    input wire logic       conv_is_cal,
    input wire logic [2:0] output_rate,
    input wire logic       unity_gain_buffer,
    input wire logic [7:0] total_gain,
    input wire logic       mains_rejection,
    input wire logic       result_valid,
    input wire logic [6:0] general_purpose_pins_oe_n,
    input wire logic       internal_osc_enable,
    input wire logic       clock_from_external
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_fast_start;
        conv_start && output_rate == 3'h7 && !conv_is_cal;
    endsequence
    property p_slot_len;
        s_fast_start |=> !conv_start [*8];
    endproperty
    property p_no_early_result;
        conv_start |=> !result_valid [*8];
    endproperty
    property p_buffer;
        total_gain >= 8'h10 |-> unity_gain_buffer;
    endproperty
    property p_gain_set;
        $onehot(total_gain);
    endproperty
    property p_mains;
        mains_rejection == (output_rate <= 3'h3);
    endproperty
    property p_clk_pair;
        clock_from_external != internal_osc_enable;
    endproperty
    property p_reset_state;
        $fell(srst) |-> internal_osc_enable && general_purpose_pins_oe_n == 7'h7F;
    endproperty
    property p_chan_range;
        conv_channel <= 3'h6;
    endproperty

    a_slot_len: assert property (p_slot_len) else $error("slot shorter than fast base");
    a_no_early_result: assert property (p_no_early_result) else $error("early result");
    a_buffer: assert property (p_buffer) else $error("buffer not forced at high gain");
    a_gain_set: assert property (p_gain_set) else $error("total gain not a power of two");
    a_mains: assert property (p_mains) else $error("mains rejection flag wrong");
    a_clk_pair: assert property (p_clk_pair) else $error("clock source flags disagree");
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    a_chan_range: assert property (p_chan_range) else $error("channel out of range");
endmodule : arc_ctrl_properties

bind arc_ctrl arc_ctrl_properties u_props (.clk, .srst, .conv_start, .conv_channel,
    .conv_is_cal, .output_rate, .unity_gain_buffer, .total_gain, .mains_rejection,
    .result_valid, .general_purpose_pins_oe_n, .internal_osc_enable, .clock_from_external);

// ==== verif/arc_mod_model.sv ====
// Modulator stand-in that returns one raw conversion four cycles into every slot.
module arc_mod_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        conv_start,
    input  wire logic [23:0] raw_value,
    output logic             raw_valid,
    output logic      [23:0] raw_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt;

    // Between strobes the data toggles so that a stale word is never mistaken for a fresh one.
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_cnt  <= 2'h0;
            raw_valid <= 1'b0;
            raw_data  <= 24'h00_0000;
        end else begin
            wait_cnt  <= conv_start ? 2'h3 : wait_cnt - 2'(wait_cnt != 2'h0);
            raw_valid <= (wait_cnt == 2'h1);
            raw_data  <= (wait_cnt == 2'h1) ? raw_value : ~raw_data;
        end
    end
endmodule : arc_mod_model

// ==== verif/tb_arc_ctrl.sv ====
// Self-checking bench for the rate and calibration controller.
module tb_arc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, wr_en, rd_en, raw_valid, conv_start, conv_is_cal, unity_gain_buffer;
    logic mains_rejection, result_valid, crystal_present, internal_osc_enable, clock_from_ext;
    logic [7:0] addr, total_gain;
    logic [31:0] wdata, rdata, d, v;
    logic [23:0] raw_data, raw_value, result, x, r, g0;
    logic [2:0] conv_channel, output_rate, result_channel;
    logic [6:0] gp_in, gp_out, gp_oe_n;
    int n_errors, comparisons, i, k;
    int unsigned seed;

    arc_ctrl #(.DIV_SLOW(64), .DIV_FAST(8)) u_dut (.clk, .srst, .addr, .wdata, .wr_en, .rd_en,
        .rdata, .raw_valid, .raw_data, .conv_start, .conv_channel, .conv_is_cal, .output_rate,
        .unity_gain_buffer, .total_gain, .mains_rejection, .result, .result_channel,
        .result_valid, .general_purpose_pins_in(gp_in), .general_purpose_pins_out(gp_out),
        .general_purpose_pins_oe_n(gp_oe_n), .crystal_present, .internal_osc_enable,
        .clock_from_external(clock_from_ext));
    arc_mod_model u_mod (.clk, .srst, .conv_start, .raw_value, .raw_valid, .raw_data);

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        wr_en <= 1'b1; addr <= a; wdata <= dat;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] dat);
        @(posedge clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 dat = rdata;
    endtask : rd
    task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, e, s);
        end
    endtask : cmp
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic poll();
        logic [31:0] p;
        for (k = 0; k < 300; k++) begin
            rd(arc_pkg::A_SYSCAL, p);
            if (p[1:0] === 2'h0) break;
        end
        if (k == 300) n_errors++;
        settle();
    endtask : poll
    task automatic wait_res();
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            #1;
            if (result_valid === 1'b1) break;
        end
        if (k == 300) n_errors++;
    endtask : wait_res
    task automatic stop_test();
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    function automatic logic [31:0] exp_div(input logic [23:0] raw, off, dv,
                                            input longint lo, hi);
        longint q;
        q = ((longint'($signed(raw)) - longint'($signed(off))) <<< 23) / longint'(dv);
        q = (q < lo) ? lo : ((q > hi) ? hi : q);
        return {8'h00, q[23:0]};
    endfunction : exp_div

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0; srst = 1; addr = 0; wdata = 0; wr_en = 0; rd_en = 0;
        gp_in = 0; crystal_present = 0; raw_value = 0; n_errors = 0; comparisons = 0;
        seed = $urandom(32'h0000_7a4b);
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(arc_pkg::A_SETUP0, d); cmp("setup0", 32'h0000_0007, d);
        rd(arc_pkg::A_GAIN0, d); cmp("gain0", 32'h0080_0000, d);
        rd(arc_pkg::A_OFFSET0, d); cmp("offset0", 32'h0000_0000, d);
        rd(8'h40, d); cmp("unmapped", 32'h0000_0000, d);
        for (i = 0; i < 128; i++) begin
            wr(arc_pkg::A_SETUP0, 32'(i));
            #1 v = (i[5] ? 32'h1 : 32'h10) << i[4:3];
            cmp("total_gain", v, 32'(total_gain));
            cmp("buffer", 32'(i[6] | (v >= 32'h10)), 32'(unity_gain_buffer));
            cmp("output_rate", 32'(i[2:0]), 32'(output_rate));
            cmp("mains", 32'(i[2:0] <= 3), 32'(mains_rejection));
        end
        wr(arc_pkg::A_SETUP0, 32'h0000_0002);
        wr(arc_pkg::A_SETUP0 + 8'h01, 32'h0000_0005);
        rd(arc_pkg::A_SETUP0, d); cmp("setup0", 32'h0000_0002, d);
        rd(arc_pkg::A_SETUP0 + 8'h01, d); cmp("setup1", 32'h0000_0005, d);
        wr(arc_pkg::A_SETUP0, 32'h0000_0007);
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            wr(arc_pkg::A_GPIO_DIR, 32'(v[6:0]));
            wr(arc_pkg::A_GPIO_OUT, 32'(v[13:7]));
            @(posedge clk) gp_in <= v[20:14];
            settle();
            rd(arc_pkg::A_GPIO_IN, d); cmp("gpio_in", 32'(v[20:14]), d);
            cmp("gpio_oe_n", {25'h0, ~v[6:0]}, 32'(gp_oe_n));
            cmp("gpio_out", 32'(v[13:7]), 32'(gp_out));
        end
        wr(arc_pkg::A_CLOCK, 32'h0000_0002); settle();
        cmp("osc_on", 32'h0, 32'(internal_osc_enable));
        wr(arc_pkg::A_CLOCK, 32'h0000_0001); settle();
        cmp("osc_on", 32'h1, 32'(internal_osc_enable));
        @(posedge clk) crystal_present <= 1'b1;
        settle();
        rd(arc_pkg::A_CLOCK, d); cmp("xtal_seen", 32'h1, 32'(d[2]));
        cmp("ext_clock", 32'h1, 32'(clock_from_ext));
        wr(arc_pkg::A_BGCAL, 32'h0000_0007);
        rd(arc_pkg::A_BGCAL, d); cmp("bgcal", 32'h0000_0007, d);
        x = 24'(($urandom & 32'h000F_FFFF) + 32'h10);
        @(posedge clk) raw_value <= x;
        wr(arc_pkg::A_SYSCAL, 32'h0000_0001); poll();
        rd(arc_pkg::A_OFFSET0, d); cmp("offset0", {8'h00, x}, d);
        wr(arc_pkg::A_GAIN0, 32'h0060_0000);
        @(posedge clk) raw_value <= x + 24'h30_0000;
        wr(arc_pkg::A_SYSCAL, 32'h0000_0003); poll();
        g0 = 24'(exp_div(x + 24'h30_0000, x, 24'h60_0000, 64'sh0, 64'shFF_FFFF));
        rd(arc_pkg::A_GAIN0, d); cmp("gain0", {8'h00, g0}, d);
        r = x + 24'(($urandom & 32'h001F_FFFF));
        @(posedge clk) raw_value <= r;
        wr(arc_pkg::A_SCAN, 32'h0000_0144);
        for (i = 0; i < 4; i++) begin
            wait_res();
            cmp("result", exp_div(r, x, g0, -64'sh80_0000, 64'sh7F_FFFF), {8'h00, result});
            cmp("result_channel", 32'h4, 32'(result_channel));
            r = (i == 2) ? x + 24'h50_0000 : x + 24'(($urandom & 32'h001F_FFFF));
            @(posedge clk) raw_value <= r;
        end
        stop_test();
    end

    initial begin
        #4_000_000;
        n_errors++;
        stop_test();
    end
endmodule : tb_arc_ctrl
